/* File: shared/mem_test_pkg.sv */
// shared constants and types for the rom/sram test access path
package mem_test_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 32;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 14;
	localparam int ROM_WORDS = 8192;
	localparam int SRAM_WORDS = 8192;
	localparam int READ_LAT = 5;
	localparam int STALL_CYCLES = 5;
	localparam int READ_STROBE_CYCLE = 4;
	localparam int VALID_CYCLE = 5;
	localparam int WRITE_STROBE_CYCLE = 3;
	localparam int WR_PERIOD = 4;
	localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;
	typedef enum logic [2:0] {
		CMD_ROM_READ = 3'h0,
		CMD_SRAM_READ = 3'h1,
		CMD_SRAM_WRITE = 3'h3,
		CMD_SRAM_WR_RD = 3'h2
	} test_cmd_e;
endpackage : mem_test_pkg

/* File: shared/mem_test_if.sv */
// test bus between the external test controller and the memory test port
`timescale 1ns/1ps
interface mem_test_if;
	import mem_test_pkg::*;
	logic test_mode;
	logic [ADDR_MSB:ADDR_LSB] test_addr;
	logic test_ctrl;
	logic rom_read_strobe;
	logic sram_read_strobe;
	logic sram_array_write_strobe;
	logic output_valid_strobe;
	logic [DATA_W-1:0] read_data_input_bus;
	logic [DATA_W-1:0] write_data_output_bus;
	modport device (
		input test_mode, test_addr, test_ctrl, rom_read_strobe, sram_read_strobe,
		input sram_array_write_strobe, output_valid_strobe, read_data_input_bus,
		output write_data_output_bus
	);
	modport controller (
		output test_mode, test_addr, test_ctrl, rom_read_strobe, sram_read_strobe,
		output sram_array_write_strobe, output_valid_strobe, read_data_input_bus,
		input write_data_output_bus
	);
endinterface : mem_test_if

/* File: core/mem_test_port.sv */
// device end: rom and sram arrays with the pipelined test access path
`timescale 1ns/1ps
module mem_test_port #(
	parameter int ROM_DEPTH = mem_test_pkg::ROM_WORDS,
	parameter int SRAM_DEPTH = mem_test_pkg::SRAM_WORDS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// test bus
	mem_test_if.device tb,
	// normal-mode sram port
	input wire logic sys_sram_we,
	input wire logic [mem_test_pkg::ADDR_W-1:0] sys_sram_addr,
	input wire logic [mem_test_pkg::DATA_W-1:0] sys_sram_wdata,
	output logic [mem_test_pkg::DATA_W-1:0] sys_sram_rdata,
	// normal-mode rom port
	input wire logic [mem_test_pkg::ADDR_W-1:0] sys_rom_addr,
	output logic [mem_test_pkg::DATA_W-1:0] sys_rom_rdata
);
	import mem_test_pkg::*;

	// depths beyond the 13-bit word address cannot be reached
	initial begin
		if (ROM_DEPTH < 1 || ROM_DEPTH > ROM_WORDS) begin
			$error("rom depth out of range");
		end
		if (SRAM_DEPTH < 1 || SRAM_DEPTH > SRAM_WORDS) begin
			$error("sram depth out of range");
		end
	end

	// rom contents are a constant pattern; a real array would be a compiled macro
	function automatic logic [DATA_W-1:0] rom_word(input logic [ADDR_W-1:0] a);
		rom_word = {~a[7:0], 3'h0, a, a[7:0]};
	endfunction : rom_word

	function automatic logic in_sram(input logic [ADDR_W-1:0] a);
		in_sram = (int'(a) < SRAM_DEPTH);
	endfunction : in_sram

	logic [DATA_W-1:0] sram_mem [SRAM_DEPTH];
	// address pipeline: index 0 is the address seen one edge ago
	logic [ADDR_W-1:0] addr_pipe_q [3];
	logic [ADDR_W-1:0] wr_addr_q;
	logic [DATA_W-1:0] wr_data_q;
	logic [DATA_W-1:0] rd_data_q;
	logic [DATA_W-1:0] out_q;
	logic [ADDR_W-1:0] wtr_addr_q;
	logic wtr_q;
	logic seq_q;
	logic ctrl_prev_q;

	// bus inputs under short names
	wire test_on = tb.test_mode;
	wire ctrl_in = tb.test_ctrl;
	wire wr_strobe = tb.sram_array_write_strobe;
	wire rd_strobe = tb.sram_read_strobe;
	wire valid_in = tb.output_valid_strobe;
	wire [ADDR_W-1:0] addr_in = tb.test_addr;
	wire [ADDR_W-1:0] rd_addr = addr_pipe_q[2];

	// a write strobe that follows sequence control belongs to a streamed write,
	// so the tail of a streamed write is never taken for write-then-read
	wire seq_live = seq_q || ctrl_in;
	wire wtr_mode = test_on && !seq_live && (wtr_q || wr_strobe);
	wire wtr_next = test_on && !seq_live
		&& (wr_strobe || (wtr_q && (rd_strobe || valid_in)));
	// write-then-read period: write, read, data, show
	wire wtr_write = wtr_mode && wtr_q && !wr_strobe && rd_strobe
		&& !valid_in;
	wire wtr_rd = wtr_mode && wtr_q && rd_strobe && valid_in && !wr_strobe;
	wire wtr_show = wtr_mode && wtr_q && valid_in && !rd_strobe;
	// held address taken at the start and whenever the strobe returns with valid
	wire wtr_take = wr_strobe && (!wtr_q || valid_in);
	wire seq_write = test_on && wr_strobe && !wtr_mode;

	// streamed reads
	wire rom_rd = test_on && tb.rom_read_strobe && (rd_addr < ROM_DEPTH);
	wire sram_rd = test_on && rd_strobe && !wtr_mode;
	wire [ADDR_W-1:0] sram_idx = rd_addr;
	wire [DATA_W-1:0] rd_next = rom_rd ? rom_word(rd_addr)
		: (sram_rd && in_sram(sram_idx)) ? sram_mem[sram_idx] : DATA_RESET;

	// sequence control seen lately; bridges the gap before a late write strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seq_q <= 1'b0;
			ctrl_prev_q <= 1'b0;
		end else begin
			seq_q <= test_on && (ctrl_in || (seq_q && (wr_strobe || ctrl_prev_q)));
			ctrl_prev_q <= ctrl_in;
		end
	end

	// address pipeline; array read happens three edges after the address
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 3; i++)
				addr_pipe_q[i] <= ADDR_RESET;
		end else begin
			addr_pipe_q[0] <= addr_in;
			addr_pipe_q[1] <= addr_pipe_q[0];
			addr_pipe_q[2] <= addr_pipe_q[1];
		end
	end

	// write capture: data pairs with the address one cycle earlier
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wr_addr_q <= ADDR_RESET;
			wr_data_q <= DATA_RESET;
		end else begin
			wr_addr_q <= addr_pipe_q[0];
			wr_data_q <= tb.read_data_input_bus;
		end
	end

	// write-then-read tracking: mode flag and held address
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wtr_q <= 1'b0;
			wtr_addr_q <= ADDR_RESET;
		end else begin
			wtr_q <= wtr_next;
			if (wtr_take)
				wtr_addr_q <= addr_in;
		end
	end

	// array write port; test writes win, normal port only outside test mode
	// a streamed-write strobe sampled in cycle k writes the data of cycle k-1 to the address of cycle k-2
	always_ff @(posedge core_clk) begin
		if (seq_write && in_sram(wr_addr_q))
			sram_mem[wr_addr_q] <= wr_data_q;
		else if (wtr_write && in_sram(wtr_addr_q))
			sram_mem[wtr_addr_q] <= wr_data_q;
		else if (!test_on && sys_sram_we && in_sram(sys_sram_addr))
			sram_mem[sys_sram_addr] <= sys_sram_wdata;
	end

	// array read stage
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= DATA_RESET;
		end else if (wtr_rd && in_sram(wtr_addr_q)) begin
			rd_data_q <= sram_mem[wtr_addr_q];
		end else if (!wtr_mode) begin
			rd_data_q <= rd_next;
		end
	end

	// output register; in write-then-read it only moves for the show cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			out_q <= DATA_RESET;
		end else if (wtr_show) begin
			out_q <= rd_data_q;
		end else if (!wtr_mode) begin
			out_q <= rd_data_q;
		end
	end

	assign tb.write_data_output_bus = out_q;
	assign sys_sram_rdata = in_sram(sys_sram_addr) ? sram_mem[sys_sram_addr] : DATA_RESET;
	assign sys_rom_rdata = (sys_rom_addr < ROM_DEPTH) ? rom_word(sys_rom_addr) : DATA_RESET;
endmodule : mem_test_port

/* File: core/mem_test_ctrl.sv */
// controller end: drives the test bus through the documented sequences
`timescale 1ns/1ps
module mem_test_ctrl (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// user command
	input wire logic cmd_valid,
	input wire mem_test_pkg::test_cmd_e cmd,
	input wire logic [mem_test_pkg::ADDR_W-1:0] cmd_base,
	input wire logic [mem_test_pkg::ADDR_W-1:0] cmd_count,
	input wire logic [mem_test_pkg::DATA_W-1:0] cmd_seed,
	output logic cmd_ready,
	// results
	output logic res_valid,
	output logic [mem_test_pkg::DATA_W-1:0] res_data,
	// test bus
	mem_test_if.controller tb
);
	import mem_test_pkg::*;

	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_DRAIN = 2'h3} state_e;
	state_e state_q;
	test_cmd_e cmd_q;
	logic [15:0] cyc_q;
	logic [ADDR_W-1:0] base_q, count_q;
	logic [DATA_W-1:0] seed_q;
	logic [ADDR_W-1:0] addr_q;
	logic [DATA_W-1:0] data_q;
	logic [3:0] drain_q;
	logic ctrl_q, rom_q, srd_q, swr_q, ov_q, resv_q;
	logic [DATA_W-1:0] res_q;

	function automatic logic [DATA_W-1:0] pattern(input logic [DATA_W-1:0] s,
		input logic [ADDR_W-1:0] a);
		pattern = s ^ {a, 6'h00, a};
	endfunction : pattern

	// cycle numbering: cyc_q = 1 is cycle one of the sequence
	wire [15:0] n = cyc_q;
	wire is_wtr = (cmd_q == CMD_SRAM_WR_RD);
	wire is_rd = (cmd_q == CMD_ROM_READ) || (cmd_q == CMD_SRAM_READ);
	wire [15:0] last_a = {3'h0, count_q};
	// wtr phase within the four-cycle period, from cycle four
	wire [1:0] ph = 2'(n - 16'd4);
	wire [15:0] pair = (n < 16'd4) ? 16'd0 : ((n - 16'd4) >> 2) + 16'd1;
	// runs last one cycle past the final show so that word is still sampled
	wire run_done = is_wtr ? (pair > last_a && ph == 2'd0)
		: is_rd ? (n >= last_a + 16'(READ_LAT) + 16'd1) : (n >= last_a + 16'd2);
	wire [15:0] ai = is_wtr ? ((n < 16'd4) ? 16'd0 : (ph == 2'd0) ? pair - 16'd1 : pair)
		: (n - 16'd1);

	// five idle cycles after every sequence
	assign cmd_ready = (state_q == ST_IDLE);
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			cmd_q <= CMD_ROM_READ;
			cyc_q <= 16'h0000;
			base_q <= ADDR_RESET;
			count_q <= ADDR_RESET;
			seed_q <= DATA_RESET;
			drain_q <= 4'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (cmd_valid && cmd_count != ADDR_RESET) begin
						state_q <= ST_RUN;
						cmd_q <= cmd;
						base_q <= cmd_base;
						count_q <= cmd_count;
						seed_q <= cmd_seed;
						cyc_q <= 16'h0001;
					end
				end
				ST_RUN: begin
					cyc_q <= cyc_q + 16'h0001;
					if (run_done) begin
						state_q <= ST_DRAIN;
						drain_q <= 4'(STALL_CYCLES);
					end
				end
				ST_DRAIN: begin
					drain_q <= drain_q - 4'h1;
					if (drain_q == 4'h1)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	wire running = (state_q == ST_RUN);
	wire [ADDR_W-1:0] a_now = base_q + ai[ADDR_W-1:0];
	wire addr_live = running && ai < last_a;
	// stream data pairs with the previous cycle's address
	wire [15:0] di = is_wtr ? ai : n - 16'd2;
	wire [ADDR_W-1:0] d_addr = base_q + di[ADDR_W-1:0];
	wire rd_strobe_d = running && is_rd && n >= 16'(READ_STROBE_CYCLE)
		&& n < last_a + 16'(READ_STROBE_CYCLE);
	wire ov_d = running && (is_wtr ? (n >= 16'(VALID_CYCLE) && (ph == 2'd1 || ph == 2'd2))
		: (n >= 16'(VALID_CYCLE) && n <= last_a + 16'(READ_LAT)));
	wire swr_d = running && (is_wtr ? (n < 16'd4 || ph == 2'd2 || ph == 2'd3)
		&& !(pair > last_a)
		: (cmd_q == CMD_SRAM_WRITE && n >= 16'(WRITE_STROBE_CYCLE)
		&& n <= last_a + 16'd2));
	wire wtr_srd_d = running && is_wtr && n >= 16'd4 && pair <= last_a
		&& (ph == 2'd0 || ph == 2'd1);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= 1'b0;
			addr_q <= ADDR_RESET;
			data_q <= DATA_RESET;
			rom_q <= 1'b0;
			srd_q <= 1'b0;
			swr_q <= 1'b0;
			ov_q <= 1'b0;
		end else begin
			ctrl_q <= running && !is_wtr && addr_live;
			addr_q <= addr_live ? a_now : ADDR_RESET;
			data_q <= pattern(seed_q, d_addr);
			rom_q <= rd_strobe_d && cmd_q == CMD_ROM_READ;
			srd_q <= (rd_strobe_d && cmd_q == CMD_SRAM_READ) || wtr_srd_d;
			swr_q <= swr_d;
			ov_q <= ov_d;
		end
	end

	// result capture: data seen while valid, or on the wtr show cycle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			resv_q <= 1'b0;
			res_q <= DATA_RESET;
		end else begin
			resv_q <= running && (is_wtr ? (n > 16'd7 && ph == 2'd0)
				: (is_rd && n > 16'd6 && n <= last_a + 16'd6));
			res_q <= tb.write_data_output_bus;
		end
	end

	assign tb.test_mode = 1'b1;
	assign tb.test_ctrl = ctrl_q;
	assign tb.test_addr = addr_q;
	assign tb.rom_read_strobe = rom_q;
	assign tb.sram_read_strobe = srd_q;
	assign tb.sram_array_write_strobe = swr_q;
	assign tb.output_valid_strobe = ov_q;
	assign tb.read_data_input_bus = data_q;
	assign res_valid = resv_q;
	assign res_data = res_q;
endmodule : mem_test_ctrl

/* File: verification/rom_sram_test_asserts.sv */
// concurrent checks on the test bus between controller and device ends
`timescale 1ns/1ps
module rom_sram_test_asserts
	import mem_test_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// test bus
	input wire logic test_mode,
	input wire logic [ADDR_MSB:ADDR_LSB] test_addr,
	input wire logic test_ctrl,
	input wire logic rom_read_strobe,
	input wire logic sram_read_strobe,
	input wire logic sram_array_write_strobe,
	input wire logic output_valid_strobe,
	input wire logic [DATA_W-1:0] read_data_input_bus,
	input wire logic [DATA_W-1:0] write_data_output_bus
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire any_rd;
	assign any_rd = rom_read_strobe | sram_read_strobe;
	sequence wrrd_read_s;
		sram_read_strobe && !sram_array_write_strobe && output_valid_strobe;
	endsequence
	sequence wrrd_write_s;
		!sram_read_strobe && sram_array_write_strobe && output_valid_strobe;
	endsequence
	sequence wrrd_show_s;
		!sram_read_strobe && sram_array_write_strobe && !output_valid_strobe;
	endsequence
	// the word written two cycles before the array write must show three cycles later
	property wrrd_data_p;
		logic [DATA_W-1:0] d;
		($fell(sram_array_write_strobe) && sram_read_strobe, d = $past(read_data_input_bus, 2))
			|-> ##3 write_data_output_bus == d;
	endproperty
	seq_start_a: assert property ($rose(test_ctrl) |-> (##2 sram_array_write_strobe) or (##3 any_rd))
		else $error("strobe missing after sequence start");
	rd_valid_a: assert property ($rose(any_rd) |=> output_valid_strobe)
		else $error("valid strobe did not follow read strobe");
	rom_start_a: assert property ($rose(rom_read_strobe) |-> $past(test_ctrl, 3))
		else $error("rom read strobe not three cycles after start");
	valid_tail_a: assert property ($fell(any_rd) && !sram_array_write_strobe |-> output_valid_strobe)
		else $error("valid dropped before last data");
	rd_wr_excl_a: assert property (!(sram_read_strobe && sram_array_write_strobe))
		else $error("sram read and write strobes together");
	rom_sram_excl_a: assert property (!(rom_read_strobe && sram_read_strobe))
		else $error("rom and sram read strobes together");
	wrrd_period_a: assert property ($fell(sram_array_write_strobe) && sram_read_strobe
		|-> !output_valid_strobe ##1 wrrd_read_s ##1 wrrd_write_s ##1 wrrd_show_s)
		else $error("write then read period broken");
	wrrd_data_a: assert property (wrrd_data_p)
		else $error("written word not shown in stall cycle");
endmodule : rom_sram_test_asserts

/* File: verification/rom_sram_test_access_bench.sv */
// self-checking bench: controller end against device end
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end
module rom_sram_test_access_bench;
	import mem_test_pkg::*;
	logic core_clk = 0;
	logic rst = 1;
	logic cmd_valid = 0;
	test_cmd_e cmd = CMD_ROM_READ;
	logic [ADDR_W-1:0] cmd_base = '0;
	logic [ADDR_W-1:0] cmd_count = '0;
	logic [DATA_W-1:0] cmd_seed = '0;
	logic cmd_ready;
	logic res_valid;
	logic [DATA_W-1:0] res_data;
	logic [DATA_W-1:0] got[$];
	int errors = 0;
	int compares = 0;
	mem_test_if bus();
	always #5 core_clk = ~core_clk;
	// normal-mode port kept busy so a leak into the test path shows up
	mem_test_port mem_test_port_inst (.core_clk(core_clk), .rst(rst), .tb(bus),
		.sys_sram_we(1'b1), .sys_sram_addr(13'h1FF5), .sys_sram_wdata(32'hDEADBEEF),
		.sys_sram_rdata(), .sys_rom_addr(13'h0003), .sys_rom_rdata());
	mem_test_ctrl mem_test_ctrl_inst (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
		.cmd(cmd), .cmd_base(cmd_base), .cmd_count(cmd_count), .cmd_seed(cmd_seed),
		.cmd_ready(cmd_ready), .res_valid(res_valid), .res_data(res_data), .tb(bus));
	rom_sram_test_asserts rom_sram_test_asserts_inst (.core_clk(core_clk), .rst(rst),
		.test_mode(bus.test_mode), .test_addr(bus.test_addr), .test_ctrl(bus.test_ctrl),
		.rom_read_strobe(bus.rom_read_strobe), .sram_read_strobe(bus.sram_read_strobe),
		.sram_array_write_strobe(bus.sram_array_write_strobe),
		.output_valid_strobe(bus.output_valid_strobe),
		.read_data_input_bus(bus.read_data_input_bus),
		.write_data_output_bus(bus.write_data_output_bus));
	// sampled mid-cycle, away from the edge that launches the result
	always @(negedge core_clk) begin
		if (res_valid === 1'b1) begin
			got.push_back(res_data);
		end
	end
	function automatic logic [DATA_W-1:0] pat(input logic [DATA_W-1:0] s, input logic [ADDR_W-1:0] a);
		return s ^ {a, 6'h00, a};
	endfunction : pat
	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	// one command, then wait for idle plus drain so late results land
	task automatic run(input test_cmd_e c, input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] n,
		input logic [DATA_W-1:0] s);
		int i;
		got.delete();
		cmd <= c;
		cmd_base <= b;
		cmd_count <= n;
		cmd_seed <= s;
		cmd_valid <= 1'b1;
		do @(posedge core_clk); while (cmd_ready !== 1'b1);
		#1 cmd_valid = 1'b0;
		i = 0;
		while (cmd_ready !== 1'b1 && i < 4000) begin
			@(posedge core_clk);
			i++;
		end
		repeat (20) @(posedge core_clk);
		#1;
	endtask : run
	task automatic check_pat(input logic [ADDR_W-1:0] b, input logic [ADDR_W-1:0] n,
		input logic [DATA_W-1:0] s);
		`CHK(got.size(), int'(n))
		for (int i = 0; i < n; i++) begin
			`CHK(got[i], pat(s, b + ADDR_W'(i)))
		end
	endtask : check_pat
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		conclude();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		#1 rst = 1'b0;
		@(posedge core_clk);
		#1;
		run(CMD_SRAM_WRITE, 13'h1FF0, 13'h0010, 32'hA5A50000);
		run(CMD_SRAM_READ, 13'h1FF0, 13'h0010, 32'hA5A50000);
		check_pat(13'h1FF0, 13'h0010, 32'hA5A50000);
		run(CMD_SRAM_WR_RD, 13'h0040, 13'h0006, 32'h12345678);
		check_pat(13'h0040, 13'h0006, 32'h12345678);
		run(CMD_SRAM_READ, 13'h0040, 13'h0006, 32'h12345678);
		check_pat(13'h0040, 13'h0006, 32'h12345678);
		run(CMD_ROM_READ, 13'h1FFC, 13'h0004, 32'h00000000);
		`CHK(got.size(), 4)
		run(CMD_ROM_READ, 13'h0000, 13'h0000, 32'h00000000);
		`CHK(got.size(), 0)
		run(CMD_SRAM_READ, 13'h1FF0, 13'h0010, 32'hA5A50000);
		check_pat(13'h1FF0, 13'h0010, 32'hA5A50000);
		conclude();
	end
endmodule : rom_sram_test_access_bench
